// ==== hw/adcs_buf2.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adcs_buf2 #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	logic [WIDTH-1:0] slot_ff [2];
	logic [WIDTH-1:0] nxt_slot [2];
	logic [1:0] count_ff;
	logic [1:0] nxt_count;
	logic doPush;
	logic doPop;

	assign inReady = (count_ff != 2'h2);
	assign outValid = (count_ff != 2'h0);
	assign outData = slot_ff[0];
	assign doPush = inValid & inReady;
	assign doPop = outValid & outReady;

	always_comb begin
		nxt_slot[0] = slot_ff[0];
		nxt_slot[1] = slot_ff[1];
		nxt_count = count_ff;
		if (doPop) begin
			nxt_slot[0] = slot_ff[1];
		end
		if (doPush) begin
			nxt_slot[(count_ff - 2'(doPop)) == 2'h0 ? 0 : 1] = inData;
		end
		nxt_count = count_ff + 2'(doPush) - 2'(doPop);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			slot_ff[0] <= '0;
			slot_ff[1] <= '0;
			count_ff <= 2'h0;
		end else begin
			slot_ff[0] <= nxt_slot[0];
			slot_ff[1] <= nxt_slot[1];
			count_ff <= nxt_count;
		end
	end
endmodule : adcs_buf2
`default_nettype wire

// ==== hw/adcs_ctrl.sv ====
// Conversion sequencer, config and result registers and the serial port of the converter.
// Assumes the analog core answers on this clock and the serial pins come from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module adcs_ctrl
	import adcs_pkg::*;
#(
	parameter int CONV_OSC = CONV_OSC_DEFAULT,
	parameter int TIMEOUT_CYC = SCLK_TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chipSelectN,
	input wire logic sclk,
	input wire logic serialIn,
	output logic serial_out_ready_n,
	output logic serialOutEn,
	output logic serialPullupOn,
	input wire logic signed [15:0] coreCode,
	input wire logic [11:0] coreTemp,
	output logic corePowerOn,
	output logic coreStart,
	output logic [2:0] range_select,
	output logic [21:0] lsbNanoVolt,
	output logic [2:0] inputSelect,
	output logic [2:0] dataRate,
	output logic temp_sensor_select,
	output logic output_pullup_enable,
	output logic singleShotMode,
	output logic [15:0] conversionWord
);
	// ********************************************************************
	// Pin synchronisers and edge detection
	// ********************************************************************
	logic [1:0] csSync_ff;
	logic [1:0] clkSync_ff;
	logic [1:0] dinSync_ff;
	logic clkPrev_ff;
	logic csPrev_ff;
	logic csHigh;
	logic sclkRise;
	logic sclkFall;
	logic csFall;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			csSync_ff <= 2'h3;
			clkSync_ff <= 2'h0;
			dinSync_ff <= 2'h0;
			clkPrev_ff <= 1'b0;
			csPrev_ff <= 1'b1;
		end else begin
			csSync_ff <= {csSync_ff[0], chipSelectN};
			clkSync_ff <= {clkSync_ff[0], sclk};
			dinSync_ff <= {dinSync_ff[0], serialIn};
			clkPrev_ff <= clkSync_ff[1];
			csPrev_ff <= csSync_ff[1];
		end
	end

	assign csHigh = csSync_ff[1];
	// Clock edges are only honoured while selected.
	assign sclkRise = ~csHigh & clkSync_ff[1] & ~clkPrev_ff;
	assign sclkFall = ~csHigh & ~clkSync_ff[1] & clkPrev_ff;
	assign csFall = csPrev_ff & ~csHigh;

	// ********************************************************************
	// Oscillator tick and conversion sequencer
	// ********************************************************************
	localparam int DIV_W = $clog2(OSC_DIV);
	localparam int CONV_W = $clog2(CONV_OSC + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
	localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_OSC - 1);
	// The clear lands on the tick that leaves exactly the lead count of ticks before the result.
	localparam logic [CONV_W-1:0] LEAD_POINT = CONV_W'(CONV_OSC - DRDY_LEAD_OSC - 1);

	logic [15:0] cfg_ff;
	logic [15:0] nxt_cfg;
	logic [15:0] conv_ff;
	logic [15:0] nxt_conv;
	logic unread_ff;
	logic nxt_unread;
	adcs_conv_e cvState_ff;
	adcs_conv_e nxt_cvState;
	logic [DIV_W-1:0] divCnt_ff;
	logic [DIV_W-1:0] nxt_divCnt;
	logic [CONV_W-1:0] convCnt_ff;
	logic [CONV_W-1:0] nxt_convCnt;
	logic startReq_ff;
	logic nxt_startReq;
	logic oscTick;
	logic convDone;
	logic [15:0] resultWord;
	logic bufInReady;
	logic bufOutValid;
	logic bufOutReady;
	logic [15:0] bufOutData;
	logic cfgWrite;
	logic [15:0] rxWord;
	logic lockNow;
	logic midFrame;

	// Saturates the core's raw count to the 12-bit span and left-aligns it.
	function automatic logic [15:0] satAlign(input logic signed [15:0] raw);
		if (raw > 16'sh07ff) begin
			satAlign = SAT_POS;
		end else if (raw < -16'sh0800) begin
			satAlign = SAT_NEG;
		end else begin
			satAlign = {raw[11:0], 4'h0};
		end
	endfunction : satAlign

	assign oscTick = (divCnt_ff == DIV_LAST);
	assign convDone = (cvState_ff == CV_RUN) & oscTick & (convCnt_ff == CONV_LAST);
	// Temperature codes are already two's complement in 0.125 C steps.
	assign resultWord = cfg_ff[CFG_TS_BIT] ? {coreTemp, 4'h0} : satAlign(coreCode);
	// The conversion register is not replaced while a frame is mid-flight.
	assign bufOutReady = ~midFrame;

	adcs_buf2 #(
		.WIDTH(WORD_BITS)
	) u_resultBuf (
		.clk(ref_clk),
		.rst(rst),
		.inValid(convDone),
		.inReady(bufInReady),
		.inData(resultWord),
		.outValid(bufOutValid),
		.outReady(bufOutReady),
		.outData(bufOutData)
	);

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_conv = conv_ff;
		nxt_unread = unread_ff;
		nxt_cvState = cvState_ff;
		nxt_divCnt = oscTick ? '0 : divCnt_ff + 1'b1;
		nxt_convCnt = convCnt_ff;
		nxt_startReq = 1'b0;
		if (cfgWrite) begin
			nxt_cfg = rxWord;
			nxt_cfg[CFG_SS_BIT] = 1'b0;
			nxt_cfg[CFG_NOP_LSB +: 2] = CFG_NOP_VALID;
			nxt_cfg[0] = cfg_ff[0];
			nxt_startReq = rxWord[CFG_SS_BIT] & rxWord[CFG_MODE_BIT];
		end
		case (cvState_ff)
			CV_DOWN: begin
				nxt_convCnt = '0;
				// A full buffer holds off the next conversion so no result is lost.
				if (bufInReady & (~cfg_ff[CFG_MODE_BIT] | startReq_ff)) begin
					nxt_cvState = CV_RUN;
				end
			end
			CV_RUN: begin
				if (oscTick) begin
					nxt_convCnt = convCnt_ff + 1'b1;
				end
				if (convDone) begin
					nxt_convCnt = '0;
					// Continuous mode starts over at once; mode one or a start ends here.
					// A word still held back by an open frame would leave no room for the next result.
					if (cfg_ff[CFG_MODE_BIT] | (bufOutValid & ~bufOutReady)) begin
						nxt_cvState = CV_DOWN;
					end
				end
			end
			default: nxt_cvState = CV_DOWN;
		endcase
		// A start seen during a running conversion is simply dropped.
		if (cvState_ff == CV_RUN) begin
			nxt_startReq = 1'b0;
		end else if (startReq_ff & ~nxt_startReq) begin
			nxt_startReq = ~(bufInReady | ~cfg_ff[CFG_MODE_BIT]);
		end
		// In continuous mode the pin returns high ahead of the next ready when nobody read the old result.
		if ((cvState_ff == CV_RUN) & ~cfg_ff[CFG_MODE_BIT] & oscTick & (convCnt_ff == LEAD_POINT)) begin
			nxt_unread = 1'b0;
		end
		if (lockNow) begin
			nxt_unread = 1'b0;
		end
		if (bufOutValid & bufOutReady) begin
			nxt_conv = bufOutData;
			nxt_unread = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg_ff <= CFG_RESET;
			conv_ff <= CONV_RESET;
			unread_ff <= 1'b0;
			cvState_ff <= CV_DOWN;
			divCnt_ff <= '0;
			convCnt_ff <= '0;
			startReq_ff <= 1'b0;
		end else begin
			cfg_ff <= nxt_cfg;
			conv_ff <= nxt_conv;
			unread_ff <= nxt_unread;
			cvState_ff <= nxt_cvState;
			divCnt_ff <= nxt_divCnt;
			convCnt_ff <= nxt_convCnt;
			startReq_ff <= nxt_startReq;
		end
	end

	// ********************************************************************
	// Serial port
	// ********************************************************************
	localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
	localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
	localparam logic [4:0] HALF_POINT = 5'(WORD_BITS);

	logic [4:0] bitCnt_ff;
	logic [4:0] nxt_bitCnt;
	logic [15:0] rx_ff;
	logic [15:0] nxt_rx;
	logic [15:0] tx_ff;
	logic [15:0] nxt_tx;
	logic outBit_ff;
	logic nxt_outBit;
	logic active_ff;
	logic nxt_active;
	logic [TO_W-1:0] idleCnt_ff;
	logic [TO_W-1:0] nxt_idleCnt;
	logic pinOut_ff;
	logic nxt_pinOut;
	logic timeout;
	logic [15:0] readback;

	assign timeout = (idleCnt_ff == TO_LAST);
	assign lockNow = sclkRise & (bitCnt_ff == 5'h0);
	assign midFrame = active_ff;
	assign rxWord = {rx_ff[14:0], dinSync_ff[1]};
	// The config word is taken on the sixteenth falling edge if the no-op field allows it.
	assign cfgWrite = sclkFall & (bitCnt_ff == HALF_POINT - 5'h1) & (rxWord[CFG_NOP_LSB +: 2] == CFG_NOP_VALID);
	// In single-shot mode the start bit reads one only when no conversion runs.
	assign readback = {cfg_ff[CFG_MODE_BIT] & (cvState_ff == CV_DOWN), cfg_ff[14:0]};

	always_comb begin
		nxt_bitCnt = bitCnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_outBit = outBit_ff;
		nxt_active = active_ff;
		nxt_idleCnt = (clkSync_ff[1] | timeout) ? '0 : idleCnt_ff + 1'b1;
		if (sclkRise) begin
			if (bitCnt_ff == 5'h0) begin
				nxt_tx = {conv_ff[14:0], 1'b0};
				nxt_outBit = conv_ff[15];
				nxt_active = 1'b1;
			end else if (bitCnt_ff == HALF_POINT) begin
				nxt_tx = {readback[14:0], 1'b0};
				nxt_outBit = readback[15];
			end else begin
				nxt_tx = {tx_ff[14:0], 1'b0};
				nxt_outBit = tx_ff[15];
			end
		end
		if (sclkFall) begin
			nxt_rx = rxWord;
			nxt_bitCnt = bitCnt_ff + 5'h1;
			// After the thirty-second bit the counter wraps and the next rise opens a new frame.
			if (bitCnt_ff == 5'(FRAME_BITS - 1)) begin
				nxt_active = 1'b0;
			end
		end
		// Deselect or a long idle clock drops any partial frame.
		if (csHigh | csFall | timeout) begin
			nxt_bitCnt = 5'h0;
			nxt_rx = '0;
			nxt_active = 1'b0;
		end
		// Outside a frame the pin shows the ready state; low means unread data.
		nxt_pinOut = nxt_active ? nxt_outBit : ~nxt_unread;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bitCnt_ff <= 5'h0;
			rx_ff <= '0;
			tx_ff <= '0;
			outBit_ff <= 1'b1;
			active_ff <= 1'b0;
			idleCnt_ff <= '0;
			pinOut_ff <= 1'b1;
		end else begin
			bitCnt_ff <= nxt_bitCnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			outBit_ff <= nxt_outBit;
			active_ff <= nxt_active;
			idleCnt_ff <= nxt_idleCnt;
			pinOut_ff <= nxt_pinOut;
		end
	end

	// ********************************************************************
	// Pin drive and configuration outputs
	// ********************************************************************
	assign serial_out_ready_n = pinOut_ff;
	assign serialOutEn = ~csHigh;
	// The pull-up only keeps the released line away from mid-supply.
	assign serialPullupOn = csHigh & cfg_ff[CFG_PULL_BIT];
	assign corePowerOn = (cvState_ff == CV_RUN);
	assign coreStart = (cvState_ff == CV_DOWN) & (nxt_cvState == CV_RUN);
	assign range_select = cfg_ff[CFG_PGA_LSB +: 3];
	assign lsbNanoVolt = lsbOfRange(cfg_ff[CFG_PGA_LSB +: 3]);
	assign inputSelect = cfg_ff[CFG_MUX_LSB +: 3];
	assign dataRate = cfg_ff[CFG_DR_LSB +: 3];
	assign temp_sensor_select = cfg_ff[CFG_TS_BIT];
	assign output_pullup_enable = cfg_ff[CFG_PULL_BIT];
	assign singleShotMode = cfg_ff[CFG_MODE_BIT];
	assign conversionWord = conv_ff;
endmodule : adcs_ctrl
`default_nettype wire

// ==== hw/adcs_pkg.sv ====
// Constants shared by the converter control block, its bound checker and its bench.
// Assumes a 125 MHz reference clock and an SPI master on the far side of the pins.
//
// What this block does
// - Range field picks one of six spans.
// - Code step equals span over four thousand ninety-six.
// - Conversion timing comes from internal 1 MHz tick.
// - Temperature result left-aligned, most significant byte first.
// - Temperature step 0.125 C, two's complement.
// - Reset loads config defaults, converter powered down.
// - Mode one: single-shot, powered down between conversions.
// - Start bit launches one conversion, reads zero while it runs.
// - Start during running conversion is ignored.
// - Mode zero: back-to-back conversions, results stored.
// - Mode one or reset leaves continuous mode.
// - Select high resets port, releases output.
// - Select low shows ready state at once.
// - Result locked into shifter for whole transfer.
// - Clock idle low; long low resets port.
// - Input sampled on falling clock, never driven.
// - Output bits change on rising clock.
// - Output low signals a new result.
// - Unread result: output high before next ready, in mode zero only.
// - Weak pull-up while deselected, unless disabled.
// - Results saturate at 7ff0h and 8000h.
// - Config shifted in during result shift-out.
// - Frames are thirty-two or sixteen bits.
package adcs_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int CLK_FREQ_HZ = 125000000;
	localparam int OSC_FREQ_HZ = 1000000;
	localparam int OSC_PERIOD_NS = 1000000000 / OSC_FREQ_HZ;
	localparam int OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
	localparam int SCLK_TIMEOUT_NS = 30800000;
	localparam int SCLK_TIMEOUT_CYC = SCLK_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int DRDY_LEAD_NS = 8000;
	localparam int DRDY_LEAD_OSC = DRDY_LEAD_NS / OSC_PERIOD_NS;
	localparam int CONV_OSC_DEFAULT = 625;
	localparam int WORD_BITS = 16;
	localparam int FRAME_BITS = 32;
	localparam logic [15:0] CFG_RESET = 16'h058b;
	localparam logic [15:0] CONV_RESET = 16'h0000;
	localparam logic [15:0] SAT_POS = 16'h7ff0;
	localparam logic [15:0] SAT_NEG = 16'h8000;
	localparam int CFG_SS_BIT = 15;
	localparam int CFG_MUX_LSB = 12;
	localparam int CFG_PGA_LSB = 9;
	localparam int CFG_MODE_BIT = 8;
	localparam int CFG_DR_LSB = 5;
	localparam int CFG_TS_BIT = 4;
	localparam int CFG_PULL_BIT = 3;
	localparam int CFG_NOP_LSB = 1;
	localparam logic [1:0] CFG_NOP_VALID = 2'h1;
	localparam logic [21:0] LSB_NV_6144 = 22'h2dc6c0;
	localparam logic [21:0] LSB_NV_4096 = 22'h1e8480;
	localparam logic [21:0] LSB_NV_2048 = 22'h0f4240;
	localparam logic [21:0] LSB_NV_1024 = 22'h07a120;
	localparam logic [21:0] LSB_NV_0512 = 22'h03d090;
	localparam logic [21:0] LSB_NV_0256 = 22'h01e848;

	typedef enum logic {CV_DOWN, CV_RUN} adcs_conv_e;

	function automatic logic [21:0] lsbOfRange(input logic [2:0] rng);
		case (rng)
			3'h0: lsbOfRange = LSB_NV_6144;
			3'h1: lsbOfRange = LSB_NV_4096;
			3'h2: lsbOfRange = LSB_NV_2048;
			3'h3: lsbOfRange = LSB_NV_1024;
			3'h4: lsbOfRange = LSB_NV_0512;
			default: lsbOfRange = LSB_NV_0256;
		endcase
	endfunction : lsbOfRange
endpackage : adcs_pkg

// ==== test/adc_conversion_spi_control_tb.sv ====
// Self-checking bench for the converter control block.
// Assumes the serial master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module adc_conversion_spi_control_tb
	import adcs_pkg::*;
;
	typedef struct packed {logic [2:0] r; logic ts; logic [15:0] code; logic [11:0] tmp; logic [15:0] w;} adcs_row_s;
	localparam int CCYC = 12 * 125;
	adcs_row_s rows [6] = '{'{3'h0, 1'b0, 16'h0123, 12'h000, 16'h1230}, '{3'h1, 1'b0, 16'h0900, 12'h000, 16'h7ff0},
		'{3'h4, 1'b0, 16'hf448, 12'h000, 16'h8000}, '{3'h3, 1'b0, 16'hffff, 12'h000, 16'hfff0},
		'{3'h5, 1'b1, 16'h0000, 12'h400, 16'h4000}, '{3'h2, 1'b1, 16'h0000, 12'hec0, 16'hec00}};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic signed [15:0] coreCode = 16'h0000;
	logic [11:0] coreTemp = 12'h000;
	wire logic chipSelectN, sclk, serialIn, dout, oe, pullOn, powerOn, coreStart, tsSel, pullEn, ssMode, pin;
	wire logic [2:0] range_select, muxSel, rate;
	wire logic [15:0] conversionWord;
	logic rdy;
	logic [31:0] rx;
	int miscompares = 0;
	int n_compared = 0;
	int starts = 0;
	int cyc = 0;
	int s0, k;
	assign pin = oe ? dout : (pullOn ? 1'b1 : ~dout);
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		starts <= starts + (coreStart === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			print_verdict();
		end
	end
	adcs_spi_master u_adcs_spi_master (.chipSelectN(chipSelectN), .sclk(sclk), .serialIn(serialIn), .pin(pin));
	adcs_ctrl #(.CONV_OSC(12), .TIMEOUT_CYC(8000)) u_adcs_ctrl (.ref_clk(ref_clk), .rst(rst),
		.chipSelectN(chipSelectN), .sclk(sclk), .serialIn(serialIn), .serial_out_ready_n(dout), .serialOutEn(oe),
		.serialPullupOn(pullOn), .coreCode(coreCode), .coreTemp(coreTemp), .corePowerOn(powerOn),
		.coreStart(coreStart), .range_select(range_select), .lsbNanoVolt(), .inputSelect(muxSel), .dataRate(rate),
		.temp_sensor_select(tsSel), .output_pullup_enable(pullEn), .singleShotMode(ssMode),
		.conversionWord(conversionWord));
	function automatic logic [31:0] cfg(logic ss, logic m, logic [2:0] r, logic ts, logic pu);
		cfg = {ss, r, r, m, r, ts, pu, 2'h1, 1'b1, 16'h0000};
	endfunction : cfg
	task automatic cycles(int n);
		repeat (n) @(negedge ref_clk);
	endtask : cycles
	task automatic waitPin(logic v);
		k = 0;
		while (pin !== v && k < 4000) begin
			@(negedge ref_clk);
			k++;
		end
	endtask : waitPin
	task automatic xfer(logic [31:0] tx, int n, logic hold);
		u_adcs_spi_master.shift(tx, n, hold, rdy, rx);
	endtask : xfer
	task automatic print_verdict();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		cycles(20);
		rst = 1'b0;
		cycles(3);
		`CHK("range", 3'h2, range_select)
		`CHK("mode", 1'b1, ssMode)
		`CHK("word", 16'h0000, conversionWord)
		`CHK("pull", 1'b1, pullOn)
		foreach (rows[i]) begin
			coreCode = rows[i].code;
			coreTemp = rows[i].tmp;
			xfer(cfg(1'b1, 1'b1, rows[i].r, rows[i].ts, 1'b1), 32, 1'b1);
			cycles(CCYC + 40);
			`CHK("power", 1'b0, powerOn)
			xfer(cfg(1'b0, 1'b1, rows[i].r, rows[i].ts, 1'b1), 32, 1'b1);
			`CHK("ready", 1'b0, rdy)
			`CHK("result", rows[i].w, rx[31:16])
			`CHK("readback", cfg(1'b1, 1'b1, rows[i].r, rows[i].ts, 1'b1) >> 16, rx[15:0])
			`CHK("rangeSel", rows[i].r, range_select)
			`CHK("tempSel", rows[i].ts, tsSel)
			`CHK("muxRate", {rows[i].r, rows[i].r}, {muxSel, rate})
		end
		s0 = starts;
		xfer(cfg(1'b1, 1'b1, 3'h2, 1'b0, 1'b1), 32, 1'b1);
		xfer(cfg(1'b1, 1'b1, 3'h2, 1'b0, 1'b1), 32, 1'b1);
		`CHK("busyBit", 1'b0, rx[15])
		cycles(CCYC);
		`CHK("starts", s0 + 1, starts)
		xfer(cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b0), 32, 1'b1);
		cycles(5);
		`CHK("pullOff", 1'b0, pullOn)
		`CHK("oe", 1'b0, oe)
		`CHK("pullBit", 1'b0, pullEn)
		coreCode = 16'h0123;
		s0 = starts;
		xfer(cfg(1'b0, 1'b0, 3'h2, 1'b0, 1'b1), 32, 1'b0);
		waitPin(1'b0);
		waitPin(1'b1);
		waitPin(1'b0);
		`CHK("lead", 1'b1, k > 995 && k < 1005)
		`CHK("cont", 17'h11230, {powerOn, conversionWord})
		// A frame held open keeps results in the buffer, so conversions must stall once it fills.
		xfer(cfg(1'b0, 1'b0, 3'h2, 1'b0, 1'b1), 4, 1'b0);
		coreCode = 16'h0456;
		s0 = starts;
		cycles(4 * CCYC);
		`CHK("stall", 1'b0, powerOn)
		xfer(cfg(1'b0, 1'b0, 3'h2, 1'b0, 1'b1) << 4, 28, 1'b1);
		`CHK("locked", 12'h230, rx[27:16])
		cycles(10);
		`CHK("drained", 16'h4560, conversionWord)
		xfer(cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b1), 32, 1'b1);
		cycles(CCYC + 50);
		s0 = starts;
		cycles(CCYC);
		`CHK("single", s0, starts)
		xfer(32'h0000_0000, 3, 1'b0);
		cycles(8100);
		xfer(cfg(1'b0, 1'b1, 3'h2, 1'b0, 1'b1), 16, 1'b1);
		`CHK("timeout", 16'h4560, rx[15:0])
		print_verdict();
	end
endmodule : adc_conversion_spi_control_tb
`default_nettype wire

// ==== test/adcs_chk.sv ====
// Port assertions for the converter control block.
// Assumes binding to adcs_ctrl, one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module adcs_chk
	import adcs_pkg::*;
#(
	parameter int CONV_OSC = CONV_OSC_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chipSelectN,
	input wire logic serial_out_ready_n,
	input wire logic serialOutEn,
	input wire logic serialPullupOn,
	input wire logic corePowerOn,
	input wire logic coreStart,
	input wire logic [2:0] range_select,
	input wire logic [21:0] lsbNanoVolt,
	input wire logic output_pullup_enable,
	input wire logic singleShotMode,
	input wire logic [15:0] conversionWord
);
	localparam int RUN_CYC = CONV_OSC * OSC_DIV;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int runCyc_ff;
	int nxt_runCyc;
	always_comb nxt_runCyc = corePowerOn ? runCyc_ff + 1 : 0;
	always_ff @(posedge ref_clk) runCyc_ff <= rst ? 0 : nxt_runCyc;
	// ***
	// Checks
	// ***
	a_oe_deselect: assert property (chipSelectN [*4] |-> !serialOutEn) else $error("pin driven while deselected");
	a_oe_select: assert property (!chipSelectN [*4] |-> serialOutEn) else $error("pin not driven while selected");
	a_pullup_gate: assert property (serialPullupOn |-> output_pullup_enable && !serialOutEn)
		else $error("pull-up on at wrong time");
	a_start_power: assert property (coreStart |=> corePowerOn) else $error("start without power");
	a_no_restart: assert property (coreStart |-> !$past(corePowerOn)) else $error("start while running");
	// The oscillator runs free, so the first conversion of a run may be up to one tick short.
	a_conv_time: assert property ($fell(corePowerOn) |-> runCyc_ff >= RUN_CYC - OSC_DIV + 1
		&& (runCyc_ff + OSC_DIV - 1) % RUN_CYC < OSC_DIV) else $error("conversion length wrong");
	a_reset_cfg: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> range_select == 3'h2 && singleShotMode
		&& output_pullup_enable && !corePowerOn && conversionWord == 16'h0000) else $error("reset state wrong");
	a_word_format: assert property ($changed(conversionWord) |-> conversionWord[3:0] == 4'h0)
		else $error("result not left-aligned");
	a_lsb_weight: assert property (lsbNanoVolt == (range_select == 3'h0 ? 22'h2dc6c0 :
		22'h1e8480 >> (range_select > 3'h5 ? 3'h4 : range_select - 3'h1))) else $error("step weight wrong");
	c_start: cover property (coreStart);
	c_ready: cover property (serialOutEn && $fell(serial_out_ready_n));
	c_cont: cover property (!singleShotMode && coreStart);
endmodule : adcs_chk
bind adcs_ctrl adcs_chk #(.CONV_OSC(CONV_OSC)) u_adcs_chk (.ref_clk(ref_clk), .rst(rst), .chipSelectN(chipSelectN),
	.serial_out_ready_n(serial_out_ready_n), .serialOutEn(serialOutEn), .serialPullupOn(serialPullupOn),
	.corePowerOn(corePowerOn), .coreStart(coreStart), .range_select(range_select), .lsbNanoVolt(lsbNanoVolt),
	.output_pullup_enable(output_pullup_enable), .singleShotMode(singleShotMode), .conversionWord(conversionWord));
`default_nettype wire

// ==== test/adcs_spi_master.sv ====
// Serial master model facing the converter pins.
// Assumes calls start on a falling edge of the 8 ns clock; the link clock period is 64 ns.
`timescale 1ns/1ps
`default_nettype none
module adcs_spi_master (
	output logic chipSelectN,
	output logic sclk,
	output logic serialIn,
	input wire logic pin
);
	initial begin
		chipSelectN = 1'b1;
		sclk = 1'b0;
		serialIn = 1'b0;
	end
	// The pin is read at each fall, half a period after the rise that launched the bit.
	task automatic shift(input logic [31:0] tx, input int n, input logic hold, output logic rdy, output logic [31:0] rx);
		rx = '0;
		chipSelectN = 1'b0;
		#64;
		rdy = pin;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			serialIn = tx[31 - i];
			#32;
			rx = {rx[30:0], pin};
			sclk = 1'b0;
			#32;
		end
		chipSelectN = hold;
		// Lets a deselect be seen before the next call can select again.
		#64;
	endtask : shift
endmodule : adcs_spi_master
`default_nettype wire
